// ### verilog/pulse_port_pkg.sv
package pulse_port_pkg;

    // --------------------------------------------------------------
    // register offsets
    // --------------------------------------------------------------
    localparam logic [15:0] OFF_P1_EDGE_SEL = 16'h32F0;
    localparam logic [15:0] OFF_P1_TOTAL = 16'h32FA;
    localparam logic [15:0] OFF_P1_SCALE = 16'h3304;
    localparam logic [15:0] OFF_P2_EDGE_SEL = 16'h330E;
    localparam logic [15:0] OFF_P2_TOTAL = 16'h3318;
    localparam logic [15:0] OFF_P2_SCALE = 16'h3322;
    localparam logic [15:0] OFF_P1_OUT_SRC = 16'h3A98;
    localparam logic [15:0] OFF_P1_OUT_POL = 16'h3AA2;
    localparam logic [15:0] OFF_P1_IO_CTRL = 16'hB036;
    localparam logic [15:0] OFF_P2_IO_CTRL = 16'hB09A;

    // --------------------------------------------------------------
    // field codes and reset values
    // --------------------------------------------------------------
    localparam int REG_W = 16;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_RISE = 2'h1;
    localparam logic [1:0] MODE_FALL = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    localparam logic [15:0] MODE_MAX = 16'h0003;
    localparam logic [15:0] SRC_NONE = 16'h0000;
    localparam logic [15:0] SRC_REAL = 16'hABE1;
    localparam logic [15:0] SRC_REACTIVE = 16'hABE8;
    localparam logic [15:0] SRC_APPARENT = 16'hABEB;
    localparam logic POL_OPEN_HIGH = 1'b0;
    localparam logic POL_CLOSED_LOW = 1'b1;
    localparam logic [16:0] SCALE_UNIT = 17'h003E8;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [9:0] RST_FRAC = 10'h000;
    localparam logic [1:0] RST_MODE = 2'h0;

endpackage

// ### verilog/pulse_input_port.sv
`timescale 1ns/1ps
module pulse_input_port #(
    parameter int W = pulse_port_pkg::REG_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic pin_in,
    input wire logic [1:0] mode,
    input wire logic [W-1:0] scale,
    output logic [W-1:0] total_r
);
    import pulse_port_pkg::*;

    // --------------------------------------------------------------
    // synchroniser and edge detect
    // --------------------------------------------------------------
    logic sync1_r, sync2_r, prev_r;
    logic rise, fall, hit;
    logic [9:0] frac_r, frac_nxt;
    logic [W-1:0] total_nxt;
    logic [16:0] sum;
    logic [16:0] units;

    assign rise = sync2_r & ~prev_r;
    assign fall = ~sync2_r & prev_r;

    always_comb begin
        hit = 1'b0;
        unique case (mode)
            MODE_OFF: hit = 1'b0;
            MODE_RISE: hit = rise;
            MODE_FALL: hit = fall;
            MODE_BOTH: hit = rise | fall;
        endcase
    end

    // --------------------------------------------------------------
    // scaled accumulator, scale held in thousandths
    // --------------------------------------------------------------
    always_comb begin
        sum = 17'(frac_r) + 17'(scale);
        units = sum / SCALE_UNIT;
        frac_nxt = frac_r;
        total_nxt = total_r;
        if (hit) begin
            frac_nxt = 10'(sum % SCALE_UNIT);
            total_nxt = total_r + W'(units);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            frac_r <= RST_FRAC;
            total_r <= RST_WORD;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            frac_r <= frac_nxt;
            total_r <= total_nxt;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_off_hold;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_OFF) |=> ($stable(total_r) && $stable(frac_r));
    endproperty
    a_off_hold: assert property (p_off_hold) else $error("counted while off");

    property p_rise_count;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_RISE && sync2_r && !prev_r && scale != '0)
        |=> (total_r != $past(total_r) || frac_r != $past(frac_r));
    endproperty
    a_rise_count: assert property (p_rise_count) else $error("rise missed");

    property p_rise_ignores_fall;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_RISE && !sync2_r && prev_r) |=> $stable(total_r);
    endproperty
    a_rise_ignores_fall: assert property (p_rise_ignores_fall) else $error("fall counted");

    property p_fall_count;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_FALL && !sync2_r && prev_r && scale != '0)
        |=> (total_r != $past(total_r) || frac_r != $past(frac_r));
    endproperty
    a_fall_count: assert property (p_fall_count) else $error("fall missed");

    property p_fall_ignores_rise;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_FALL && sync2_r && !prev_r) |=> ($stable(frac_r) && $stable(total_r));
    endproperty
    a_fall_ignores_rise: assert property (p_fall_ignores_rise) else $error("rise counted");

    property p_both_count;
        @(posedge clk) disable iff (!resetn)
        (mode == MODE_BOTH && (sync2_r != prev_r) && scale == SCALE_UNIT[W-1:0])
        |=> (total_r == $past(total_r) + 1'b1);
    endproperty
    a_both_count: assert property (p_both_count) else $error("edge miscount");

    property p_scale_unit;
        @(posedge clk) disable iff (!resetn)
        (hit && frac_r == RST_FRAC && scale < SCALE_UNIT[W-1:0]) |=> $stable(total_r);
    endproperty
    a_scale_unit: assert property (p_scale_unit) else $error("fraction leaked");

endmodule

// ### verilog/pulse_port_counter_output.sv
`timescale 1ns/1ps
// Behaviour
// - input config 0: no counting, port back to on/off control
// - input config 1: count rising edges only
// - input config 2: count falling edges only
// - input config 3: count both edges
// - any input edge mode turns port pulse output off
// - nonzero port 1 input config forces port 1 output control to zero
// - nonzero port 2 input config forces port 2 output control to zero
// - each port accumulator shows counted pulses times scale factor
// - scale setting holds factor times one thousand
// - port 1 source: 0 switch, else real, reactive or apparent pulses
// - port 1 polarity: 0 idles high, 1 idles low
module pulse_port_counter_output #(
    parameter int W = pulse_port_pkg::REG_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata_r,
    input wire logic energy_real_pulse,
    input wire logic energy_reactive_pulse,
    input wire logic energy_apparent_pulse,
    input wire logic port1_in,
    output logic port1_out_r,
    output logic port1_oe_r,
    input wire logic port2_in,
    output logic port2_out_r,
    output logic port2_oe_r
);
    import pulse_port_pkg::*;

    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mode_ok(input logic [15:0] v);
        mode_ok = (v <= MODE_MAX);
    endfunction

    // --------------------------------------------------------------
    // configuration registers
    // --------------------------------------------------------------
    logic [1:0] p1_mode_r, p1_mode_nxt, p2_mode_r, p2_mode_nxt;
    logic [W-1:0] p1_scale_r, p1_scale_nxt, p2_scale_r, p2_scale_nxt;
    logic [15:0] p1_src_r, p1_src_nxt;
    logic p1_pol_r, p1_pol_nxt;
    logic p1_ctrl_r, p1_ctrl_nxt, p2_ctrl_r, p2_ctrl_nxt;
    logic [W-1:0] p1_total, p2_total;

    always_comb begin
        p1_mode_nxt = p1_mode_r;
        p2_mode_nxt = p2_mode_r;
        p1_scale_nxt = p1_scale_r;
        p2_scale_nxt = p2_scale_r;
        p1_src_nxt = p1_src_r;
        p1_pol_nxt = p1_pol_r;
        p1_ctrl_nxt = p1_ctrl_r;
        p2_ctrl_nxt = p2_ctrl_r;
        if (reg_wr) begin
            if (hit(reg_addr, OFF_P1_IO_CTRL)) p1_ctrl_nxt = (reg_wdata != RST_WORD);
            if (hit(reg_addr, OFF_P2_IO_CTRL)) p2_ctrl_nxt = (reg_wdata != RST_WORD);
            if (hit(reg_addr, OFF_P1_SCALE)) p1_scale_nxt = reg_wdata[W-1:0];
            if (hit(reg_addr, OFF_P2_SCALE)) p2_scale_nxt = reg_wdata[W-1:0];
            if (hit(reg_addr, OFF_P1_OUT_POL)) p1_pol_nxt = reg_wdata[0];
            if (hit(reg_addr, OFF_P1_OUT_SRC) &&
                (reg_wdata == SRC_NONE || reg_wdata == SRC_REAL ||
                 reg_wdata == SRC_REACTIVE || reg_wdata == SRC_APPARENT)) begin
                p1_src_nxt = reg_wdata;
            end
            if (hit(reg_addr, OFF_P1_EDGE_SEL) && mode_ok(reg_wdata)) begin
                p1_mode_nxt = reg_wdata[1:0];
                if (reg_wdata != RST_WORD) begin
                    p1_ctrl_nxt = 1'b0;
                    p1_src_nxt = SRC_NONE;
                end
            end
            if (hit(reg_addr, OFF_P2_EDGE_SEL) && mode_ok(reg_wdata)) begin
                p2_mode_nxt = reg_wdata[1:0];
                if (reg_wdata != RST_WORD) begin
                    p2_ctrl_nxt = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_mode_r <= RST_MODE;
            p2_mode_r <= RST_MODE;
            p1_scale_r <= RST_WORD;
            p2_scale_r <= RST_WORD;
            p1_src_r <= SRC_NONE;
            p1_pol_r <= POL_OPEN_HIGH;
            p1_ctrl_r <= 1'b0;
            p2_ctrl_r <= 1'b0;
        end else begin
            p1_mode_r <= p1_mode_nxt;
            p2_mode_r <= p2_mode_nxt;
            p1_scale_r <= p1_scale_nxt;
            p2_scale_r <= p2_scale_nxt;
            p1_src_r <= p1_src_nxt;
            p1_pol_r <= p1_pol_nxt;
            p1_ctrl_r <= p1_ctrl_nxt;
            p2_ctrl_r <= p2_ctrl_nxt;
        end
    end

    // --------------------------------------------------------------
    // pulse input counters
    // --------------------------------------------------------------
    pulse_input_port #(.W(W)) u_port1 (
        .clk(clk),
        .resetn(resetn),
        .pin_in(port1_in),
        .mode(p1_mode_r),
        .scale(p1_scale_r),
        .total_r(p1_total)
    );

    pulse_input_port #(.W(W)) u_port2 (
        .clk(clk),
        .resetn(resetn),
        .pin_in(port2_in),
        .mode(p2_mode_r),
        .scale(p2_scale_r),
        .total_r(p2_total)
    );

    // --------------------------------------------------------------
    // pin drive and read data
    // --------------------------------------------------------------
    logic sel_pulse;
    logic p1_out_nxt, p1_oe_nxt, p2_out_nxt, p2_oe_nxt;
    logic [15:0] rdata_nxt;

    always_comb begin
        unique case (p1_src_r)
            SRC_REAL: sel_pulse = energy_real_pulse;
            SRC_REACTIVE: sel_pulse = energy_reactive_pulse;
            SRC_APPARENT: sel_pulse = energy_apparent_pulse;
            default: sel_pulse = 1'b0;
        endcase
        p1_oe_nxt = (p1_mode_r == MODE_OFF);
        p2_oe_nxt = (p2_mode_r == MODE_OFF);
        p2_out_nxt = p2_ctrl_r;
        if (p1_src_r == SRC_NONE) begin
            p1_out_nxt = p1_ctrl_r;
        end else begin
            p1_out_nxt = (p1_pol_r == POL_OPEN_HIGH) ? ~sel_pulse : sel_pulse;
        end
        rdata_nxt = reg_rdata_r;
        if (reg_rd) begin
            rdata_nxt = RST_WORD;
            if (hit(reg_addr, OFF_P1_EDGE_SEL)) rdata_nxt = 16'(p1_mode_r);
            if (hit(reg_addr, OFF_P2_EDGE_SEL)) rdata_nxt = 16'(p2_mode_r);
            if (hit(reg_addr, OFF_P1_TOTAL)) rdata_nxt = 16'(p1_total);
            if (hit(reg_addr, OFF_P2_TOTAL)) rdata_nxt = 16'(p2_total);
            if (hit(reg_addr, OFF_P1_SCALE)) rdata_nxt = 16'(p1_scale_r);
            if (hit(reg_addr, OFF_P2_SCALE)) rdata_nxt = 16'(p2_scale_r);
            if (hit(reg_addr, OFF_P1_OUT_SRC)) rdata_nxt = p1_src_r;
            if (hit(reg_addr, OFF_P1_OUT_POL)) rdata_nxt = 16'(p1_pol_r);
            if (hit(reg_addr, OFF_P1_IO_CTRL)) rdata_nxt = 16'(p1_ctrl_r);
            if (hit(reg_addr, OFF_P2_IO_CTRL)) rdata_nxt = 16'(p2_ctrl_r);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            port1_out_r <= 1'b0;
            port1_oe_r <= 1'b0;
            port2_out_r <= 1'b0;
            port2_oe_r <= 1'b0;
            reg_rdata_r <= RST_WORD;
        end else begin
            port1_out_r <= p1_out_nxt;
            port1_oe_r <= p1_oe_nxt;
            port2_out_r <= p2_out_nxt;
            port2_oe_r <= p2_oe_nxt;
            reg_rdata_r <= rdata_nxt;
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_force_ctrl1;
        @(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == OFF_P1_EDGE_SEL && reg_wdata != RST_WORD && reg_wdata <= MODE_MAX)
        |=> (p1_ctrl_r == 1'b0 && p1_src_r == SRC_NONE) ##1 !port1_oe_r;
    endproperty
    a_force_ctrl1: assert property (p_force_ctrl1) else $error("port 1 not forced");

    property p_force_ctrl2;
        @(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == OFF_P2_EDGE_SEL && reg_wdata != RST_WORD && reg_wdata <= MODE_MAX)
        |=> (p2_ctrl_r == 1'b0) ##1 !port2_oe_r;
    endproperty
    a_force_ctrl2: assert property (p_force_ctrl2) else $error("port 2 not forced");

    property p_out_off;
        @(posedge clk) disable iff (!resetn)
        (p1_mode_r != MODE_OFF) |=> !port1_oe_r;
    endproperty
    a_out_off: assert property (p_out_off) else $error("pulse out with input mode");

    property p_idle_level;
        @(posedge clk) disable iff (!resetn)
        (p1_src_r != SRC_NONE && !sel_pulse && !reg_wr)
        |=> (port1_out_r == (p1_pol_r == POL_OPEN_HIGH));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("wrong idle level");

    property p_real_pulse;
        @(posedge clk) disable iff (!resetn)
        (p1_src_r == SRC_REAL && !reg_wr)
        |=> (port1_out_r == ($past(energy_real_pulse) ^ (p1_pol_r == POL_OPEN_HIGH)));
    endproperty
    a_real_pulse: assert property (p_real_pulse) else $error("real pulse not passed");

endmodule

// ### sim/pulse_source.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// external pulse source: n full pulses, each level held hold cycles
// --------------------------------------------------------------
module pulse_source (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] n_pulses,
    input wire logic [3:0] hold,
    output logic pin_drv,
    output logic busy
);
    int cnt = 0;
    int lvl_cnt = 0;
    initial begin
        pin_drv = 1'b0;
        busy = 1'b0;
    end
    // idle low between bursts; each level is held hold cycles, one cycle when hold is 0 or 1
    always @(posedge clk) begin
        if (go && !busy) begin
            busy <= 1'b1;
            cnt <= 2 * n_pulses;
            lvl_cnt <= hold;
        end else if (busy) begin
            if (lvl_cnt > 1) begin
                lvl_cnt <= lvl_cnt - 1;
            end else if (cnt == 0) begin
                busy <= 1'b0;
            end else begin
                pin_drv <= ~pin_drv;
                cnt <= cnt - 1;
                lvl_cnt <= hold;
            end
        end
    end
endmodule

// ### sim/test_pulse_port_counter_output.sv
`timescale 1ns/1ps
module test_pulse_port_counter_output;
    import pulse_port_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata_r;
    logic [2:0] epulse = 3'h0;
    logic p1_out, p1_oe, p2_out, p2_oe, drv, busy;
    logic go = 1'b0;
    logic [3:0] n_pulses = 4'h0;
    logic [3:0] hold = 4'h2;
    int err_total = 0;
    int n_tests = 0;
    int tot[2] = '{0, 0};
    int frac[2] = '{0, 0};
    int scl[2] = '{0, 0};
    logic [1:0] mode[2] = '{2'h0, 2'h0};
    wire logic p1_pin = p1_oe ? p1_out : drv;
    wire logic p2_pin = p2_oe ? p2_out : drv;
    logic [15:0] rst_addr[9] = '{OFF_P1_EDGE_SEL, OFF_P1_TOTAL, OFF_P1_SCALE, OFF_P2_EDGE_SEL,
        OFF_P2_TOTAL, OFF_P2_SCALE, OFF_P1_OUT_SRC, OFF_P1_OUT_POL, 16'h1234};
    logic [15:0] src_code[3] = '{SRC_REAL, SRC_REACTIVE, SRC_APPARENT};

    always #2.5 clk = ~clk;

    pulse_port_counter_output pulse_port_counter_output_i (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .energy_real_pulse(epulse[0]),
        .energy_reactive_pulse(epulse[1]), .energy_apparent_pulse(epulse[2]),
        .port1_in(p1_pin), .port1_out_r(p1_out), .port1_oe_r(p1_oe),
        .port2_in(p2_pin), .port2_out_r(p2_out), .port2_oe_r(p2_oe)
    );
    pulse_source pulse_source_i (
        .clk(clk), .go(go), .n_pulses(n_pulses), .hold(hold), .pin_drv(drv), .busy(busy)
    );

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic complete_run();
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata_r, exp);
    endtask
    task automatic settle();
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic set_mode(input int p, input logic [1:0] m);
        wr(p == 0 ? OFF_P1_EDGE_SEL : OFF_P2_EDGE_SEL, {14'h0000, m});
        mode[p] = m;
    endtask
    task automatic edges(input int p, input int n);
        for (int e = 0; e < n; e++) begin
            frac[p] += scl[p];
            tot[p] = (tot[p] + frac[p] / 1000) % 65536;
            frac[p] = frac[p] % 1000;
        end
    endtask
    task automatic pulses(input logic [3:0] n, input logic [3:0] h);
        int k;
        @(posedge clk);
        n_pulses <= n;
        hold <= h;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
        k = 0;
        while (busy && k < 300) begin
            @(posedge clk);
            k++;
        end
        if (k == 300) begin
            err_total++;
            complete_run();
        end
        repeat (6) @(posedge clk);
        for (int p = 0; p < 2; p++) begin
            edges(p, mode[p] == MODE_BOTH ? 2 * n : (mode[p] != MODE_OFF ? n : 0));
        end
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        foreach (rst_addr[i]) rd(rst_addr[i], RST_WORD);
        chk({15'h0000, p1_oe}, 16'h0001);
        wr(OFF_P1_SCALE, 16'h09C4);
        scl[0] = 2500;
        for (int i = 0; i < 3; i++) begin
            wr(OFF_P1_IO_CTRL, 16'h0001);
            settle();
            chk({15'h0000, p1_out}, 16'h0001);
            wr(OFF_P1_IO_CTRL, 16'h0000);
        end
        rd(OFF_P1_TOTAL, 16'h0000);
        wr(OFF_P1_OUT_POL, 16'h0001);
        wr(OFF_P1_OUT_SRC, SRC_REAL);
        wr(OFF_P1_IO_CTRL, 16'h0001);
        rd(OFF_P1_OUT_SRC, SRC_REAL);
        set_mode(0, MODE_RISE);
        rd(OFF_P1_OUT_SRC, SRC_NONE);
        rd(OFF_P1_IO_CTRL, 16'h0000);
        chk({15'h0000, p1_oe}, 16'h0000);
        pulses(4'h3, 4'h2);
        rd(OFF_P1_TOTAL, tot[0][15:0]);
        set_mode(0, MODE_FALL);
        pulses(4'h2, 4'h5);
        rd(OFF_P1_TOTAL, tot[0][15:0]);
        wr(OFF_P2_SCALE, 16'h03E8);
        scl[1] = 1000;
        wr(OFF_P2_IO_CTRL, 16'h0001);
        settle();
        chk({15'h0000, p2_out}, 16'h0001);
        set_mode(1, MODE_BOTH);
        rd(OFF_P2_IO_CTRL, 16'h0000);
        settle();
        chk({15'h0000, p2_oe}, 16'h0000);
        edges(1, 1);
        set_mode(0, MODE_BOTH);
        pulses(4'h3, 4'h2);
        rd(OFF_P1_TOTAL, tot[0][15:0]);
        rd(OFF_P2_TOTAL, tot[1][15:0]);
        wr(OFF_P1_EDGE_SEL, 16'h0004);
        rd(OFF_P1_EDGE_SEL, 16'h0003);
        wr(OFF_P1_TOTAL, 16'h5555);
        rd(OFF_P1_TOTAL, tot[0][15:0]);
        set_mode(0, MODE_OFF);
        settle();
        chk({15'h0000, p1_oe}, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_P1_OUT_SRC, src_code[i]);
            for (int pol = 0; pol < 2; pol++) begin
                wr(OFF_P1_OUT_POL, pol[15:0]);
                for (int lvl = 0; lvl < 2; lvl++) begin
                    @(posedge clk);
                    epulse <= (lvl == 1) ? (3'h1 << i) : 3'h0;
                    settle();
                    chk({15'h0000, p1_out}, {15'h0000, pol[0] ~^ lvl[0]});
                end
            end
        end
        wr(OFF_P1_OUT_SRC, 16'h1234);
        rd(OFF_P1_OUT_SRC, SRC_APPARENT);
        complete_run();
    end
endmodule
